// file: verification/ppc_board_model.sv
// Board side of both ports: a pull-up on every pin.
module ppc_board_model (
  input  wire logic [7:0] p3_out_i,
  input  wire logic [7:0] p3_oe_i,
  input  wire logic [7:0] pf_out_i,
  input  wire logic [7:0] pf_oe_i,
  output logic      [7:0] p3_lvl_o,
  output logic      [7:0] pf_lvl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released pin is pulled high, so an open-drain one reads back as one.
  assign p3_lvl_o = (p3_out_i & p3_oe_i) | ~p3_oe_i;
  assign pf_lvl_o = (pf_out_i & pf_oe_i) | ~pf_oe_i;
endmodule

// file: verification/tb_port_pin_control_clock_out.sv
module tb_port_pin_control_clock_out;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CK = ppc_pkg::PF_CLKOUT_BIT;
  localparam int SB = ppc_pkg::PF_STROBE_BIT;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  ppc_pkg::ppc_apb_req_t req = '0;
  ppc_pkg::ppc_apb_rsp_t rsp;
  logic [1:0]            pwr = 2'h0;
  logic [2:0]            mode = 3'h0;
  logic [7:0]            ser_d = 8'h00;
  logic [7:0]            ser_oe = 8'h00;
  logic                  strobe_n = 1'b1;
  logic [7:0]            p3_o, p3_oe, pf_o, pf_oe, p3_i, pf_i;
  logic                  ext_interrupt_3_input_n;
  logic [31:0]           rd;
  logic                  err;
  logic                  prev;
  int                    error_cnt = 0;
  int                    checks = 0;
  int                    cycles = 0;

  // Clock and a run-time ceiling that ends a hang.
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  ppc_port_ctrl u_ppc_port_ctrl (.CLK_I(clk), .RST_N_I(rst_n), .APB_I(req), .APB_O(rsp), .POWER_STATE_I(pwr),
    .OP_MODE_I(mode), .SER_DATA_I(ser_d), .SER_OE_I(ser_oe), .LOW_BYTE_WRITE_STROBE_N_I(strobe_n),
    .P3_PIN_I(p3_i), .P3_PIN_O(p3_o), .P3_PIN_OE_O(p3_oe), .PF_PIN_I(pf_i), .PF_PIN_O(pf_o),
    .PF_PIN_OE_O(pf_oe), .EXT_INTERRUPT_3_INPUT_N_O(ext_interrupt_3_input_n));
  ppc_board_model u_ppc_board_model (.p3_out_i(p3_o), .p3_oe_i(p3_oe), .pf_out_i(pf_o), .pf_oe_i(pf_oe),
    .p3_lvl_o(p3_i), .pf_lvl_o(pf_i));

  // Compares one result and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high, and only the run ceiling ends the wait.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, addr, wdata};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  // Latch read-back, single-bit update and a write-only direction register.
  task automatic t_latch();
    apb(1, ppc_pkg::ADDR_P3_LATCH, 32'ha5);
    apb(0, ppc_pkg::ADDR_P3_LATCH, 0);
    chk(rd, 32'ha5);
    apb(1, ppc_pkg::ADDR_P3_LATCH, rd | 32'h40);
    apb(1, ppc_pkg::ADDR_P3_DIR, 32'h0f);
    apb(0, ppc_pkg::ADDR_P3_DIR, 0);
    chk(rd, 0);
    apb(0, ppc_pkg::ADDR_P3_LATCH, 0);
    chk(rd, 32'he5);
    apb(1, ppc_pkg::ADDR_PF_LATCH, 32'h3c);
    apb(0, ppc_pkg::ADDR_PF_LATCH, 0);
    chk(rd, 32'h3c);
    chk({p3_oe, p3_o & p3_oe}, 16'h0f05);
    $display("test latch done");
  endtask

  // Samples the clock pin twice; either it toggles or it holds exp = {oe, out}.
  task automatic pin7(input logic tog, input logic [1:0] exp);
    repeat (3) @(posedge clk);
    prev = pf_o[CK] & pf_oe[CK];
    @(posedge clk);
    if (tog) chk({pf_oe[CK], pf_o[CK]}, {1'b1, ~prev});
    else chk({pf_oe[CK], prev, pf_o[CK] & pf_oe[CK]}, {exp[1], exp[0], exp[0]});
  endtask

  // Clock pin over direction, stop bit and every power state.
  task automatic t_clock();
    for (int d = 0; d < 2; d++) begin
      for (int s = 0; s < 2; s++) begin
        apb(1, ppc_pkg::ADDR_PF_DIR, d ? 32'h80 : 32'h0);
        apb(1, ppc_pkg::ADDR_SYS_CLK, s ? 32'h1 << ppc_pkg::CLK_STOP_BIT : 32'h0);
        apb(0, ppc_pkg::ADDR_SYS_CLK, 0);
        chk(rd, s ? 32'h1 << ppc_pkg::CLK_STOP_BIT : 32'h0);
        for (int p = 0; p < 4; p++) begin
          pwr <= p[1:0];
          pin7(d && !s && p < 2, (d && p < 3) ? 2'h3 : 2'h0);
        end
        pwr <= ppc_pkg::PWR_NORMAL;
      end
    end
    $display("test clock done");
  endtask

  // Open-drain on port 3, for latch data and for serial outputs.
  task automatic t_od();
    apb(1, ppc_pkg::ADDR_P3_DIR, 0);
    apb(1, ppc_pkg::ADDR_P3_OD, 32'h0f);
    apb(0, ppc_pkg::ADDR_P3_OD, 0);
    chk(rd, 32'h0f);
    apb(1, ppc_pkg::ADDR_P3_LATCH, 32'h05);
    apb(1, ppc_pkg::ADDR_P3_DIR, 32'hff);
    repeat (3) @(posedge clk);
    chk({p3_oe, p3_o & p3_oe}, 16'hfa00);
    apb(0, ppc_pkg::ADDR_P3_PINS, 0);
    chk(rd, 32'h05);
    ser_oe <= 8'h11;
    ser_d <= 8'h10;
    repeat (3) @(posedge clk);
    chk({p3_oe[4], p3_o[4], p3_oe[0], p3_o[0]}, 4'he);
    ser_d <= 8'h11;
    repeat (3) @(posedge clk);
    chk({p3_oe[4], p3_o[4], p3_oe[0]}, 3'h6);
    ser_oe <= 8'h00;
    $display("test open drain done");
  endtask

  // Strobe takeover of port F bit 3 in every operating mode.
  task automatic t_strobe();
    apb(1, ppc_pkg::ADDR_PF_DIR, 32'h08);
    apb(1, ppc_pkg::ADDR_PF_LATCH, 32'h00);
    for (int m = 0; m < 8; m++) begin
      for (int s = 0; s < 2; s++) begin
        mode <= m[2:0];
        strobe_n <= s[0];
        repeat (4) @(posedge clk);
        chk({pf_oe[SB], pf_o[SB], ext_interrupt_3_input_n}, (m inside {1, 2, 4, 5, 6}) ? {2'h2 | s[0], 1'b1} : 3'h4);
      end
    end
    $display("test strobe done");
  endtask

  // Unmapped address and a write to a read-only pin register.
  task automatic t_err();
    apb(0, 8'h20, 0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1, ppc_pkg::ADDR_P3_PINS, 32'hff);
    chk(err, 1);
    $display("test error done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Reset, then every scenario in turn.
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({p3_oe, pf_oe, rsp.pready, ext_interrupt_3_input_n}, 18'h1);
    t_latch();
    t_clock();
    t_od();
    t_strobe();
    t_err();
    test_done();
  end
endmodule

// file: verilog/ppc_pad_cell.sv
// Registered pin driver: push-pull or open-drain, with a forced release.
module ppc_pad_cell (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             en_i,
  input  wire logic             data_i,
  input  wire logic             od_i,
  input  wire logic             hiz_i,
  output ppc_pkg::ppc_pad_t     pad_o
);

  ppc_pkg::ppc_pad_t st;
  ppc_pkg::ppc_pad_t next_st;

  // Open-drain pulls low for a zero and releases for a one.
  always_comb begin
    next_st.out = data_i;
    next_st.oe  = en_i & ~hiz_i;
    if (od_i) begin
      next_st.out = 1'b0;
      next_st.oe  = en_i & ~hiz_i & ~data_i;
    end
  end

  // Pad state register.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pad_o = st;

  a_od_never_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    od_i |=> !(st.oe && st.out)) else $error("open-drain pin drove high");

endmodule

// file: verilog/ppc_pkg.sv
package ppc_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] ADDR_P3_LATCH = 8'h00;
  localparam logic [7:0] ADDR_P3_DIR   = 8'h04;
  localparam logic [7:0] ADDR_P3_OD    = 8'h08;
  localparam logic [7:0] ADDR_P3_PINS  = 8'h0c;
  localparam logic [7:0] ADDR_PF_LATCH = 8'h10;
  localparam logic [7:0] ADDR_PF_DIR   = 8'h14;
  localparam logic [7:0] ADDR_PF_PINS  = 8'h18;
  localparam logic [7:0] ADDR_SYS_CLK  = 8'h1c;

  // Reset value of every port register.
  localparam logic [7:0] PORT_RESET = 8'h00;

  // Field positions.
  localparam int CLK_STOP_BIT  = 3;
  localparam int PF_STROBE_BIT = 3;
  localparam int PF_CLKOUT_BIT = 7;

  // Power state codes on the power state input.
  localparam logic [1:0] PWR_NORMAL  = 2'h0;
  localparam logic [1:0] PWR_SLEEP   = 2'h1;
  localparam logic [1:0] PWR_SW_STBY = 2'h2;
  localparam logic [1:0] PWR_HW_STBY = 2'h3;

  // One bit per operating mode; set where the external bus owns the strobe pin.
  localparam logic [7:0] BUS_MODE_MASK = 8'h76;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ppc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } ppc_apb_rsp_t;

  typedef struct packed {
    logic out;
    logic oe;
  } ppc_pad_t;

endpackage

// file: verilog/ppc_port_ctrl.sv
// Behaviour
// - Output latch readable and writable at any time.
// - Direction registers write-only, read back zero.
// - Stop bit fixes clock pin high.
// - Clock pin direction zero gives high impedance.
// - Clock pin state follows power state.
// - Port 3 open-drain bit selects open-drain.
// - Open-drain also applies to serial outputs.
// - Bus modes give strobe pin, no interrupt.
//
// Local design decisions: the register addresses and the APB register port.
module ppc_port_ctrl (
  input  wire logic                  CLK_I,
  input  wire logic                  RST_N_I,
  input  ppc_pkg::ppc_apb_req_t      APB_I,
  output ppc_pkg::ppc_apb_rsp_t      APB_O,
  input  wire logic [1:0]            POWER_STATE_I,
  input  wire logic [2:0]            OP_MODE_I,
  input  wire logic [7:0]            SER_DATA_I,
  input  wire logic [7:0]            SER_OE_I,
  input  wire logic                  LOW_BYTE_WRITE_STROBE_N_I,
  input  wire logic [7:0]            P3_PIN_I,
  output logic      [7:0]            P3_PIN_O,
  output logic      [7:0]            P3_PIN_OE_O,
  input  wire logic [7:0]            PF_PIN_I,
  output logic      [7:0]            PF_PIN_O,
  output logic      [7:0]            PF_PIN_OE_O,
  output logic                       EXT_INTERRUPT_3_INPUT_N_O
);

  typedef struct packed {
    logic [7:0]            p3_latch;
    logic [7:0]            p3_dir;
    logic [7:0]            p3_od;
    logic [7:0]            pf_latch;
    logic [7:0]            pf_dir;
    logic                  clock_out_stop;
    logic                  clk_tog;
    logic                  ext_interrupt_3_input_n;
    ppc_pkg::ppc_apb_rsp_t rsp;
  } ppc_state_t;

  ppc_state_t st;
  ppc_state_t next_st;
  logic       setup;
  logic       wr;
  logic       bus_mode;
  logic [15:0] pin_en;
  logic [15:0] pin_data;
  logic [15:0] pin_od;
  logic        hw_stby;
  ppc_pkg::ppc_pad_t pads [16];

  assign setup    = APB_I.psel & ~APB_I.penable;
  assign wr       = APB_I.psel & APB_I.penable & st.rsp.pready & APB_I.pwrite;
  assign bus_mode = ppc_pkg::BUS_MODE_MASK[OP_MODE_I];
  assign hw_stby  = (POWER_STATE_I == ppc_pkg::PWR_HW_STBY);

  // Bus slave, register file and clock divider next state.
  always_comb begin
    next_st             = st;
    next_st.clk_tog     = ~st.clk_tog;
    next_st.ext_interrupt_3_input_n      = bus_mode ? 1'b1 : PF_PIN_I[ppc_pkg::PF_STROBE_BIT];
    next_st.rsp.pready  = setup;
    next_st.rsp.pslverr = 1'b0;
    next_st.rsp.prdata  = '0;
    if (setup && !APB_I.pwrite) begin
      unique case (APB_I.paddr)
        ppc_pkg::ADDR_P3_LATCH: next_st.rsp.prdata[7:0] = st.p3_latch;
        ppc_pkg::ADDR_P3_DIR:   next_st.rsp.prdata      = '0;
        ppc_pkg::ADDR_P3_OD:    next_st.rsp.prdata[7:0] = st.p3_od;
        ppc_pkg::ADDR_P3_PINS:  next_st.rsp.prdata[7:0] = P3_PIN_I;
        ppc_pkg::ADDR_PF_LATCH: next_st.rsp.prdata[7:0] = st.pf_latch;
        ppc_pkg::ADDR_PF_DIR:   next_st.rsp.prdata      = '0;
        ppc_pkg::ADDR_PF_PINS:  next_st.rsp.prdata[7:0] = PF_PIN_I;
        ppc_pkg::ADDR_SYS_CLK:  next_st.rsp.prdata[ppc_pkg::CLK_STOP_BIT] = st.clock_out_stop;
        default:                next_st.rsp.pslverr = 1'b1;
      endcase
    end else if (setup) begin
      unique case (APB_I.paddr)
        ppc_pkg::ADDR_P3_LATCH, ppc_pkg::ADDR_P3_DIR, ppc_pkg::ADDR_P3_OD,
        ppc_pkg::ADDR_PF_LATCH, ppc_pkg::ADDR_PF_DIR, ppc_pkg::ADDR_SYS_CLK: next_st.rsp.pslverr = 1'b0;
        default:                next_st.rsp.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      unique case (APB_I.paddr)
        ppc_pkg::ADDR_P3_LATCH: next_st.p3_latch = APB_I.pwdata[7:0];
        ppc_pkg::ADDR_P3_DIR:   next_st.p3_dir   = APB_I.pwdata[7:0];
        ppc_pkg::ADDR_P3_OD:    next_st.p3_od    = APB_I.pwdata[7:0];
        ppc_pkg::ADDR_PF_LATCH: next_st.pf_latch = APB_I.pwdata[7:0];
        ppc_pkg::ADDR_PF_DIR:   next_st.pf_dir   = APB_I.pwdata[7:0];
        // Only the stop bit is stored; other bits of this word are ignored.
        ppc_pkg::ADDR_SYS_CLK:  next_st.clock_out_stop = APB_I.pwdata[ppc_pkg::CLK_STOP_BIT];
        default:                next_st.rsp.pslverr = next_st.rsp.pslverr;
      endcase
    end
  end

  // State register.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      st          <= '0;
      st.p3_latch <= ppc_pkg::PORT_RESET;
      st.p3_dir   <= ppc_pkg::PORT_RESET;
      st.p3_od    <= ppc_pkg::PORT_RESET;
      st.pf_latch <= ppc_pkg::PORT_RESET;
      st.pf_dir   <= ppc_pkg::PORT_RESET;
      st.ext_interrupt_3_input_n   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Per pin source selection; pins 0 to 7 are port 3, 8 to 15 port F.
  for (genvar i = 0; i < 16; i++) begin : g_pin
    if (i < 8) begin : g_p3
      always_comb begin
        pin_data[i] = SER_OE_I[i] ? SER_DATA_I[i] : st.p3_latch[i];
        pin_en[i]   = SER_OE_I[i] | st.p3_dir[i];
        pin_od[i]   = st.p3_od[i];
      end
    end else if (i - 8 == ppc_pkg::PF_STROBE_BIT) begin : g_strobe
      always_comb begin
        pin_data[i] = bus_mode ? LOW_BYTE_WRITE_STROBE_N_I : st.pf_latch[i-8];
        pin_en[i]   = bus_mode | st.pf_dir[i-8];
        pin_od[i]   = 1'b0;
      end
    end else if (i - 8 == ppc_pkg::PF_CLKOUT_BIT) begin : g_clk
      // Hardware standby release comes from the common hiz input.
      always_comb begin
        pin_en[i]   = st.pf_dir[i-8];
        pin_data[i] = st.clock_out_stop | (POWER_STATE_I == ppc_pkg::PWR_SW_STBY) | st.clk_tog;
        pin_od[i]   = 1'b0;
      end
    end else begin : g_pf
      always_comb begin
        pin_data[i] = st.pf_latch[i-8];
        pin_en[i]   = st.pf_dir[i-8];
        pin_od[i]   = 1'b0;
      end
    end
    ppc_pad_cell u_pad (
      .clk_i   (CLK_I),
      .rst_n_i (RST_N_I),
      .en_i    (pin_en[i]),
      .data_i  (pin_data[i]),
      .od_i    (pin_od[i]),
      .hiz_i   (hw_stby),
      .pad_o   (pads[i])
    );
    if (i < 8) begin : g_o3
      assign P3_PIN_O[i]    = pads[i].out;
      assign P3_PIN_OE_O[i] = pads[i].oe;
    end else begin : g_of
      assign PF_PIN_O[i-8]    = pads[i].out;
      assign PF_PIN_OE_O[i-8] = pads[i].oe;
    end
  end

  assign APB_O                     = st.rsp;
  assign EXT_INTERRUPT_3_INPUT_N_O = st.ext_interrupt_3_input_n;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_latch_readback: assert property (
    setup && !APB_I.pwrite && APB_I.paddr == ppc_pkg::ADDR_P3_LATCH |=> APB_O.prdata == {24'h000000, $past(st.p3_latch)})
    else $error("port 3 latch read mismatch");
  a_dir_reads_zero: assert property (
    setup && APB_I.paddr == ppc_pkg::ADDR_PF_DIR |=> APB_O.prdata == 32'h00000000 && APB_O.pready)
    else $error("direction register read not zero");
  a_clk_fixed_high: assert property (
    (st.clock_out_stop && st.pf_dir[7] && POWER_STATE_I == ppc_pkg::PWR_NORMAL) [*2] |-> PF_PIN_O[7] && PF_PIN_OE_O[7])
    else $error("stopped clock pin not high");
  a_clk_input_hiz: assert property (
    !st.pf_dir[7] |=> !PF_PIN_OE_O[7]) else $error("clock pin driven while input");
  a_hw_stby_hiz: assert property (
    hw_stby |=> PF_PIN_OE_O == 8'h00 && P3_PIN_OE_O == 8'h00) else $error("pin driven in hardware standby");
  a_sw_stby_high: assert property (
    POWER_STATE_I == ppc_pkg::PWR_SW_STBY && st.pf_dir[7] |=> PF_PIN_O[7] && PF_PIN_OE_O[7])
    else $error("clock pin not high in software standby");
  a_clk_toggles: assert property (
    (!st.clock_out_stop && st.pf_dir[7] && POWER_STATE_I == ppc_pkg::PWR_SLEEP) [*3] |-> PF_PIN_O[7] != $past(PF_PIN_O[7]))
    else $error("clock pin not toggling");
  a_od_port3: assert property (
    st.p3_od[1] && st.p3_dir[1] && !SER_OE_I[1] && !hw_stby |=> P3_PIN_OE_O[1] == !$past(st.p3_latch[1]) && !P3_PIN_O[1])
    else $error("port 3 open-drain wrong");
  a_od_serial: assert property (
    SER_OE_I[0] && st.p3_od[0] && !SER_DATA_I[0] && !hw_stby |=> P3_PIN_OE_O[0] && !P3_PIN_O[0])
    else $error("serial open-drain low not driven");
  a_strobe_takeover: assert property (
    bus_mode && !hw_stby |=> PF_PIN_OE_O[3] && PF_PIN_O[3] == $past(LOW_BYTE_WRITE_STROBE_N_I) && EXT_INTERRUPT_3_INPUT_N_O)
    else $error("strobe pin not taken over");

  c_clk_running: cover property ((!st.clock_out_stop && st.pf_dir[7] && POWER_STATE_I == ppc_pkg::PWR_NORMAL) [*4]);
  c_strobe_mode: cover property (bus_mode && !LOW_BYTE_WRITE_STROBE_N_I);
  c_od_serial:   cover property (SER_OE_I[0] && st.p3_od[0] && !SER_DATA_I[0]);
  c_slverr:      cover property (APB_O.pslverr);

endmodule
